// File: hdl/adc_ctrl_cfg.svh
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH
`define AVS_ADDR_W      8
`define AVS_DATA_W      32
`define OFS_NORMAL_MODE 8'h00
`define OFS_FIRST_MODE  8'h04
`define OFS_SECOND_MODE 8'h08
`define OFS_TRIGGER     8'h0C
`define BIT_START       0
`define BIT_SCAN        1
`define BIT_NORM_BUSY   6
`define BIT_NORM_DONE   7
`define BIT_REF_EN      7
`define BIT_IDLE_RUN    6
`define BIT_SCAN_WIDE   5
`define BIT_PRIO_DONE   7
`define BIT_PRIO_BUSY   6
`define BIT_PRIO_START  5
`define BIT_PRIO_SRC    7
`define BIT_PRIO_HWEN   6
`define BIT_NORM_SRC    5
`define BIT_NORM_HWEN   4
`define CH_MSB          3
`define SRST_MSB        1
`define RSVD_MSB        31
`define RSVD_LSB        8
`define SRST_ARM        2'h2
`define SRST_FIRE       2'h1
`define CH_LOW_BASE     4'h4
`define CH_HIGH_BASE    4'h8
`define CH_STEP         4'h1
`endif

// File: hdl/adc_ctrl_pkg.sv
`include "adc_ctrl_cfg.svh"
package adc_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_NORM = 3'b010,
    ST_PRIO = 3'b100
  } engine_state_t;
  typedef enum logic [2:0] {
    REG_NONE, REG_NORMAL, REG_FIRST, REG_SECOND, REG_TRIGGER
  } reg_id_t;
  typedef struct packed {
    logic             scan;
    logic             wide;
    logic [`CH_MSB:0] channel;
    logic [`CH_MSB:0] prio_channel;
  } mode_cfg_t;
  typedef struct packed {
    logic             start;
    logic             prio;
    logic [`CH_MSB:0] channel;
  } conv_cmd_t;
endpackage : adc_ctrl_pkg

// File: hdl/hw_trigger_select.sv
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module hw_trigger_select (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Trigger sources
  input  wire logic ext_trigger_i,
  input  wire logic timer5_compare_zero_i,
  input  wire logic timer6_compare_zero_i,
  // Selection
  input  wire logic prio_src_i,
  input  wire logic prio_en_i,
  input  wire logic norm_src_i,
  input  wire logic norm_en_i,
  // Start pulses
  output logic      prio_hw_o,
  output logic      norm_hw_o
);
  logic ext_prev_reg;
  logic t5_prev_reg;
  logic t6_prev_reg;
  logic ext_edge;
  logic ext_to_prio;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_prev_reg <= 1'b0;
      t5_prev_reg  <= 1'b0;
      t6_prev_reg  <= 1'b0;
    end else begin
      ext_prev_reg <= ext_trigger_i;
      t5_prev_reg  <= timer5_compare_zero_i;
      t6_prev_reg  <= timer6_compare_zero_i;
    end
  end

  assign ext_edge    = ext_trigger_i & ~ext_prev_reg;
  // One external pin cannot serve both; priority keeps it
  assign ext_to_prio = prio_en_i & ~prio_src_i;
  assign prio_hw_o   = prio_en_i & (prio_src_i ?
                       (timer5_compare_zero_i & ~t5_prev_reg) : ext_edge);
  assign norm_hw_o   = norm_en_i & (norm_src_i ?
                       (timer6_compare_zero_i & ~t6_prev_reg) :
                       (ext_edge & ~ext_to_prio));
endmodule : hw_trigger_select

// File: hdl/conv_engine.sv
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module conv_engine import adc_ctrl_pkg::*; (
  // Clock and reset
  input  wire logic      ref_clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      soft_rst_i,
  // Requests and mode
  input  wire logic      norm_start_i,
  input  wire logic      prio_start_i,
  input  wire logic      run_en_i,
  input  wire mode_cfg_t cfg_i,
  // Converter side
  input  wire logic      conv_done_i,
  output conv_cmd_t      cmd_o,
  // Status
  output logic           norm_busy_o,
  output logic           prio_busy_o,
  output logic           norm_done_o,
  output logic           prio_done_o
);
  engine_state_t    state_reg;
  logic             pend_norm_reg;
  logic             pend_prio_reg;
  logic             issued_reg;
  logic             norm_active_reg;
  logic [`CH_MSB:0] chan_reg;
  logic             take_prio;
  logic             take_norm;

  function automatic logic [`CH_MSB:0] first_channel(input mode_cfg_t c);
    if (!c.scan)
      first_channel = c.channel;
    else if (c.wide || c.channel[`CH_MSB])
      first_channel = `CH_HIGH_BASE;
    else
      first_channel = `CH_LOW_BASE;
  endfunction : first_channel

  assign take_prio   = pend_prio_reg & (state_reg != ST_PRIO);
  assign take_norm   = pend_norm_reg & ~pend_prio_reg & (state_reg == ST_IDLE);
  assign norm_busy_o = norm_active_reg;
  assign prio_busy_o = (state_reg == ST_PRIO);

  // Pending requests; a new request wins over its own take
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_norm_reg <= 1'b0;
      pend_prio_reg <= 1'b0;
    end else if (soft_rst_i) begin
      pend_norm_reg <= 1'b0;
      pend_prio_reg <= 1'b0;
    end else begin
      if (norm_start_i)
        pend_norm_reg <= 1'b1;
      else if (take_norm)
        pend_norm_reg <= 1'b0;
      if (prio_start_i)
        pend_prio_reg <= 1'b1;
      else if (take_prio)
        pend_prio_reg <= 1'b0;
    end
  end

  // Sequencer; priority preempts and normal restarts its channel after
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg       <= ST_IDLE;
      issued_reg      <= 1'b0;
      norm_active_reg <= 1'b0;
      chan_reg        <= '0;
      cmd_o           <= '0;
      norm_done_o     <= 1'b0;
      prio_done_o     <= 1'b0;
    end else if (soft_rst_i) begin
      state_reg       <= ST_IDLE;
      issued_reg      <= 1'b0;
      norm_active_reg <= 1'b0;
      chan_reg        <= '0;
      cmd_o           <= '0;
      norm_done_o     <= 1'b0;
      prio_done_o     <= 1'b0;
    end else begin
      cmd_o.start <= 1'b0;
      norm_done_o <= 1'b0;
      prio_done_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          issued_reg <= 1'b0;
          if (take_prio) begin
            state_reg <= ST_PRIO;
          end else if (take_norm) begin
            state_reg       <= ST_NORM;
            norm_active_reg <= 1'b1;
            chan_reg        <= first_channel(cfg_i);
          end
        end
        ST_NORM: begin
          if (pend_prio_reg) begin
            state_reg  <= ST_PRIO;
            issued_reg <= 1'b0;
          end else if (!issued_reg) begin
            if (run_en_i) begin
              cmd_o      <= '{start: 1'b1, prio: 1'b0, channel: chan_reg};
              issued_reg <= 1'b1;
            end
          end else if (conv_done_i) begin
            issued_reg <= 1'b0;
            if (chan_reg == cfg_i.channel) begin
              state_reg       <= ST_IDLE;
              norm_active_reg <= 1'b0;
              norm_done_o     <= 1'b1;
            end else begin
              chan_reg <= chan_reg + `CH_STEP;
            end
          end
        end
        ST_PRIO: begin
          if (!issued_reg) begin
            if (run_en_i) begin
              cmd_o      <= '{start: 1'b1, prio: 1'b1,
                              channel: cfg_i.prio_channel};
              issued_reg <= 1'b1;
            end
          end else if (conv_done_i) begin
            issued_reg  <= 1'b0;
            prio_done_o <= 1'b1;
            state_reg   <= norm_active_reg ? ST_NORM : ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule : conv_engine

// File: hdl/adc_mode_trigger_control.sv
// Overview of operation
// - Idle-run bit stops or keeps converting.
// - Scan width bit picks four or eight; here, when set, it only makes the sweep start at input 8.
// - Fixed mode channel codes map inputs 4-11.
// - Scan sweeps from input 4 or 8.
// - Priority done flag set on completion.
// - Reading second mode register clears done.
// - Priority busy flag high while converting.
// - Writing priority start bit launches; reads zero.
// - Priority channel field selects single input.
// - Priority source bit picks pin or timer5.
// - Priority hardware start enable bit.
// - Normal source bit picks pin or timer6.
// - Normal hardware start enable bit.
// - Reset field 10 then 01 resets.
// - Soft reset clears all these registers.
// - Upper bits read zero, reserved bit four.
// - Normal start bit reads zero; scan bit.
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module adc_mode_trigger_control import adc_ctrl_pkg::*; (
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // Avalon-MM slave
  input  wire logic [`AVS_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [`AVS_DATA_W-1:0] avs_writedata_i,
  output logic      [`AVS_DATA_W-1:0] avs_readdata_o,
  output logic                        avs_waitrequest_o,
  // Converter side
  input  wire logic                   conv_done_i,
  output logic                        conv_start_o,
  output logic                        conv_priority_o,
  output logic      [`CH_MSB:0]       conv_channel_o,
  output logic                        reference_enable_o,
  // System and triggers
  input  wire logic                   system_idle_i,
  input  wire logic                   ext_trigger_i,
  input  wire logic                   timer5_compare_zero_i,
  input  wire logic                   timer6_compare_zero_i
);
  logic                   ack_reg;
  logic [`AVS_DATA_W-1:0] readdata_reg;
  logic [`AVS_DATA_W-1:0] rd_word;
  logic                   wr_fire;
  logic                   rd_fire;
  reg_id_t                sel;

  logic                   scan_reg;
  logic                   norm_done_reg;
  logic                   ref_en_reg;
  logic                   idle_run_reg;
  logic                   wide_reg;
  logic [`CH_MSB:0]       channel_reg;
  logic                   prio_done_reg;
  logic [`CH_MSB:0]       prio_channel_reg;
  logic                   prio_src_reg;
  logic                   prio_hwen_reg;
  logic                   norm_src_reg;
  logic                   norm_hwen_reg;
  logic                   srst_armed_reg;
  logic                   soft_rst_reg;

  logic                   sw_norm_start;
  logic                   sw_prio_start;
  logic                   hw_norm_start;
  logic                   hw_prio_start;
  logic                   norm_start;
  logic                   prio_start;
  logic                   run_en;
  logic                   norm_busy;
  logic                   prio_busy;
  logic                   norm_done_pulse;
  logic                   prio_done_pulse;
  mode_cfg_t              mode_cfg;
  conv_cmd_t              cmd;

  function automatic reg_id_t reg_sel(input logic [`AVS_ADDR_W-1:0] a);
    if (a == `OFS_NORMAL_MODE)
      reg_sel = REG_NORMAL;
    else if (a == `OFS_FIRST_MODE)
      reg_sel = REG_FIRST;
    else if (a == `OFS_SECOND_MODE)
      reg_sel = REG_SECOND;
    else if (a == `OFS_TRIGGER)
      reg_sel = REG_TRIGGER;
    else
      reg_sel = REG_NONE;
  endfunction : reg_sel

  // One wait state: data is captured first, then handed over
  assign sel               = reg_sel(avs_address_i);
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_fire           = avs_write_i & ack_reg;
  assign rd_fire           = avs_read_i & ack_reg;
  assign avs_readdata_o    = readdata_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      ack_reg <= 1'b0;
    else if (ack_reg)
      ack_reg <= 1'b0;
    else if (avs_read_i || avs_write_i)
      ack_reg <= 1'b1;
  end

  always_comb begin
    rd_word = '0;
    if (sel == REG_NORMAL) begin
      rd_word[`BIT_NORM_DONE] = norm_done_reg;
      rd_word[`BIT_NORM_BUSY] = norm_busy;
      rd_word[`BIT_SCAN]      = scan_reg;
    end else if (sel == REG_FIRST) begin
      rd_word[`BIT_REF_EN]    = ref_en_reg;
      rd_word[`BIT_IDLE_RUN]  = idle_run_reg;
      rd_word[`BIT_SCAN_WIDE] = wide_reg;
      rd_word[`CH_MSB:0]      = channel_reg;
    end else if (sel == REG_SECOND) begin
      rd_word[`BIT_PRIO_DONE] = prio_done_reg;
      rd_word[`BIT_PRIO_BUSY] = prio_busy;
      rd_word[`CH_MSB:0]      = prio_channel_reg;
    end else if (sel == REG_TRIGGER) begin
      rd_word[`BIT_PRIO_SRC]  = prio_src_reg;
      rd_word[`BIT_PRIO_HWEN] = prio_hwen_reg;
      rd_word[`BIT_NORM_SRC]  = norm_src_reg;
      rd_word[`BIT_NORM_HWEN] = norm_hwen_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      readdata_reg <= '0;
    else if (avs_read_i && !ack_reg)
      readdata_reg <= rd_word;
  end

  // Writable fields; start bits and reserved bits are not stored
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_reg         <= 1'b0;
      ref_en_reg       <= 1'b0;
      idle_run_reg     <= 1'b0;
      wide_reg         <= 1'b0;
      channel_reg      <= '0;
      prio_channel_reg <= '0;
      prio_src_reg     <= 1'b0;
      prio_hwen_reg    <= 1'b0;
      norm_src_reg     <= 1'b0;
      norm_hwen_reg    <= 1'b0;
    end else if (soft_rst_reg) begin
      scan_reg         <= 1'b0;
      ref_en_reg       <= 1'b0;
      idle_run_reg     <= 1'b0;
      wide_reg         <= 1'b0;
      channel_reg      <= '0;
      prio_channel_reg <= '0;
      prio_src_reg     <= 1'b0;
      prio_hwen_reg    <= 1'b0;
      norm_src_reg     <= 1'b0;
      norm_hwen_reg    <= 1'b0;
    end else if (wr_fire) begin
      if (sel == REG_NORMAL) begin
        scan_reg <= avs_writedata_i[`BIT_SCAN];
      end else if (sel == REG_FIRST) begin
        ref_en_reg   <= avs_writedata_i[`BIT_REF_EN];
        idle_run_reg <= avs_writedata_i[`BIT_IDLE_RUN];
        wide_reg     <= avs_writedata_i[`BIT_SCAN_WIDE];
        channel_reg  <= avs_writedata_i[`CH_MSB:0];
      end else if (sel == REG_SECOND) begin
        prio_channel_reg <= avs_writedata_i[`CH_MSB:0];
      end else if (sel == REG_TRIGGER) begin
        prio_src_reg  <= avs_writedata_i[`BIT_PRIO_SRC];
        prio_hwen_reg <= avs_writedata_i[`BIT_PRIO_HWEN];
        norm_src_reg  <= avs_writedata_i[`BIT_NORM_SRC];
        norm_hwen_reg <= avs_writedata_i[`BIT_NORM_HWEN];
      end
    end
  end

  // Completion flags; a completion in the clearing read wins
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      norm_done_reg <= 1'b0;
      prio_done_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      norm_done_reg <= 1'b0;
      prio_done_reg <= 1'b0;
    end else begin
      if (norm_done_pulse)
        norm_done_reg <= 1'b1;
      else if (rd_fire && sel == REG_NORMAL)
        norm_done_reg <= 1'b0;
      if (prio_done_pulse)
        prio_done_reg <= 1'b1;
      else if (rd_fire && sel == REG_SECOND)
        prio_done_reg <= 1'b0;
    end
  end

  // Two-write unlock; any other code in between disarms
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      srst_armed_reg <= 1'b0;
      soft_rst_reg   <= 1'b0;
    end else begin
      soft_rst_reg <= 1'b0;
      if (wr_fire && sel == REG_TRIGGER) begin
        if (avs_writedata_i[`SRST_MSB:0] == `SRST_ARM) begin
          srst_armed_reg <= 1'b1;
        end else begin
          srst_armed_reg <= 1'b0;
          soft_rst_reg   <= srst_armed_reg &&
                            avs_writedata_i[`SRST_MSB:0] == `SRST_FIRE;
        end
      end
    end
  end

  assign sw_norm_start = wr_fire && sel == REG_NORMAL &&
                         avs_writedata_i[`BIT_START];
  assign sw_prio_start = wr_fire && sel == REG_SECOND &&
                         avs_writedata_i[`BIT_PRIO_START];
  assign norm_start    = sw_norm_start | hw_norm_start;
  assign prio_start    = sw_prio_start | hw_prio_start;
  // Reference must be on; idle halts unless told to run
  assign run_en        = ref_en_reg & (~system_idle_i | idle_run_reg);
  assign mode_cfg      = '{scan: scan_reg, wide: wide_reg,
                           channel: channel_reg,
                           prio_channel: prio_channel_reg};

  hw_trigger_select u_trig (
    .ref_clk_i             (ref_clk_i),
    .rst_n_i               (rst_n_i),
    .ext_trigger_i         (ext_trigger_i),
    .timer5_compare_zero_i (timer5_compare_zero_i),
    .timer6_compare_zero_i (timer6_compare_zero_i),
    .prio_src_i            (prio_src_reg),
    .prio_en_i             (prio_hwen_reg),
    .norm_src_i            (norm_src_reg),
    .norm_en_i             (norm_hwen_reg),
    .prio_hw_o             (hw_prio_start),
    .norm_hw_o             (hw_norm_start)
  );

  conv_engine u_engine (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .soft_rst_i   (soft_rst_reg),
    .norm_start_i (norm_start),
    .prio_start_i (prio_start),
    .run_en_i     (run_en),
    .cfg_i        (mode_cfg),
    .conv_done_i  (conv_done_i),
    .cmd_o        (cmd),
    .norm_busy_o  (norm_busy),
    .prio_busy_o  (prio_busy),
    .norm_done_o  (norm_done_pulse),
    .prio_done_o  (prio_done_pulse)
  );

  assign conv_start_o       = cmd.start;
  assign conv_priority_o    = cmd.prio;
  assign conv_channel_o     = cmd.channel;
  assign reference_enable_o = ref_en_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_arm;
    wr_fire && sel == REG_TRIGGER &&
    avs_writedata_i[`SRST_MSB:0] == `SRST_ARM;
  endsequence
  sequence s_fire;
    wr_fire && sel == REG_TRIGGER && srst_armed_reg &&
    avs_writedata_i[`SRST_MSB:0] == `SRST_FIRE;
  endsequence
  sequence s_preempt;
    prio_start && norm_busy && !prio_busy;
  endsequence

  a_idle_stop:
    assert property (system_idle_i && !idle_run_reg |=> !conv_start_o)
    else $error("start issued while idle stop selected");
  a_fixed_chan:
    assert property (conv_start_o && !conv_priority_o && !scan_reg
                     |-> conv_channel_o == channel_reg)
    else $error("fixed mode started wrong channel");
  a_done_set:
    assert property (prio_done_pulse |=> prio_done_reg)
    else $error("priority done flag not set");
  a_read_clear:
    assert property (rd_fire && sel == REG_SECOND && !prio_done_pulse
                     |=> !prio_done_reg)
    else $error("priority done flag not cleared by read");
  a_busy_flag:
    assert property (conv_start_o && conv_priority_o |-> prio_busy)
    else $error("priority start without busy flag");
  a_start_zero:
    assert property (rd_fire && sel == REG_SECOND
                     |-> !avs_readdata_o[`BIT_PRIO_START])
    else $error("priority start bit read as one");
  a_prio_chan:
    assert property (conv_start_o && conv_priority_o
                     |-> conv_channel_o == prio_channel_reg)
    else $error("priority conversion on wrong channel");
  a_timer5_start:
    assert property (prio_hwen_reg && prio_src_reg &&
                     $rose(timer5_compare_zero_i) |-> prio_start)
    else $error("timer5 match did not start priority");
  a_timer6_start:
    assert property (norm_hwen_reg && norm_src_reg &&
                     $rose(timer6_compare_zero_i) |-> norm_start)
    else $error("timer6 match did not start normal");
  a_srst_armed:
    assert property (soft_rst_reg |-> $past(srst_armed_reg))
    else $error("soft reset without arming write");
  a_srst_clear:
    assert property (s_fire |=> ##1 (!ref_en_reg && !prio_hwen_reg &&
                     channel_reg == '0 && !scan_reg))
    else $error("soft reset left a register set");
  a_arm_hold:
    assert property (s_arm |=> srst_armed_reg)
    else $error("arming write not remembered");
  a_rsvd_zero:
    assert property (rd_fire
                     |-> avs_readdata_o[`RSVD_MSB:`RSVD_LSB] == '0)
    else $error("reserved upper bits not zero");
  a_preempt:
    assert property (s_preempt |-> ##[1:2] prio_busy)
    else $error("priority request not serviced first");
endmodule : adc_mode_trigger_control

// File: verification/adc_conv_model.sv
`timescale 1ns/1ps
module adc_conv_model #(
  parameter int DLY = 12
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Converter handshake
  input  wire logic conv_start_i,
  output logic      conv_done_o
);
  int cnt_reg;
  // One conversion at a time; a new start restarts the count
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg     <= 0;
      conv_done_o <= 1'b0;
    end else begin
      conv_done_o <= (cnt_reg == 1);
      if (conv_start_i) cnt_reg <= DLY;
      else if (cnt_reg != 0) cnt_reg <= cnt_reg - 1;
    end
  end
endmodule : adc_conv_model

// File: verification/adc_mode_trigger_control_tb.sv
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module adc_mode_trigger_control_tb;
  logic        ref_clk_i, rst_n_i, avs_read_i, avs_write_i;
  logic [7:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic        avs_waitrequest_o, conv_done_i, conv_start_o;
  logic        conv_priority_o, reference_enable_o, system_idle_i;
  logic        ext_trigger_i, timer5_compare_zero_i, timer6_compare_zero_i;
  logic [3:0]  conv_channel_o;
  logic [4:0]  chq[$];
  int          fail_count, n_compared;

  adc_mode_trigger_control dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
    .conv_priority_o(conv_priority_o), .conv_channel_o(conv_channel_o),
    .reference_enable_o(reference_enable_o), .system_idle_i(system_idle_i),
    .ext_trigger_i(ext_trigger_i),
    .timer5_compare_zero_i(timer5_compare_zero_i),
    .timer6_compare_zero_i(timer6_compare_zero_i));
  adc_conv_model #(.DLY(12)) conv (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .conv_start_i(conv_start_o), .conv_done_o(conv_done_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Log every command as {priority, channel}
  always @(posedge ref_clk_i) begin
    if (conv_start_o === 1'b1) chq.push_back({conv_priority_o, conv_channel_o});
  end

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    if (n >= 50) begin
      fail_count++;
      results();
    end
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task automatic wst(input int n);
    int i;
    for (i = 0; i < 300 && chq.size() < n; i++) @(posedge ref_clk_i);
    if (chq.size() < n) begin
      fail_count++;
      results();
    end
  endtask : wst
  task automatic pulse(input logic t5);
    @(posedge ref_clk_i);
    if (t5) timer5_compare_zero_i <= 1'b1;
    else timer6_compare_zero_i <= 1'b1;
    @(posedge ref_clk_i);
    timer5_compare_zero_i <= 1'b0;
    timer6_compare_zero_i <= 1'b0;
  endtask : pulse

  initial begin
    {rst_n_i, avs_read_i, avs_write_i, system_idle_i, ext_trigger_i} = 5'h00;
    {timer5_compare_zero_i, timer6_compare_zero_i} = 2'h0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    fail_count = 0;
    n_compared = 0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h0C, 32'h0);
    wr(8'h10, 32'hFF);
    rdc(8'h10, 32'h0);
    wr(8'h04, 32'hFFFFFF6B);
    rdc(8'h04, 32'h6B);
    $display("test registers done");
    wr(8'h04, 32'h86);
    repeat (300) @(posedge ref_clk_i);
    chk(reference_enable_o, 1'b1);
    rdc(8'h04, 32'h86);
    wr(8'h00, 32'h03);
    wst(3);
    chk(chq[0], 5'h04);
    chk(chq[2], 5'h06);
    // Let the sweep finish so busy is low and done is set
    repeat (20) @(posedge ref_clk_i);
    rdc(8'h00, 32'h82);
    chq.delete();
    wr(8'h04, 32'hAA);
    wr(8'h00, 32'h03);
    wst(3);
    chk({chq[0], chq[2]}, 10'h10A);
    $display("test scan done");
    chq.delete();
    wr(8'h08, 32'h29);
    wst(1);
    chk(chq[0], 5'h19);
    rdc(8'h08, 32'h49);
    repeat (40) @(posedge ref_clk_i);
    rdc(8'h08, 32'h89);
    rdc(8'h08, 32'h09);
    $display("test priority done");
    chq.delete();
    wr(8'h04, 32'h84);
    system_idle_i <= 1'b1;
    wr(8'h08, 32'h25);
    repeat (30) @(posedge ref_clk_i);
    chk(chq.size(), 0);
    system_idle_i <= 1'b0;
    wst(1);
    chk(chq[0], 5'h15);
    repeat (40) @(posedge ref_clk_i);
    rdc(8'h08, 32'h85);
    chq.delete();
    wr(8'h04, 32'hC4);
    system_idle_i <= 1'b1;
    wr(8'h08, 32'h25);
    wst(1);
    chk(chq[0], 5'h15);
    system_idle_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    $display("test idle done");
    chq.delete();
    wr(8'h0C, 32'hE0);
    pulse(1'b0);
    repeat (20) @(posedge ref_clk_i);
    chk(chq.size(), 0);
    pulse(1'b1);
    wst(1);
    chk(chq[0], 5'h15);
    repeat (40) @(posedge ref_clk_i);
    chq.delete();
    wr(8'h0C, 32'hB0);
    pulse(1'b1);
    repeat (20) @(posedge ref_clk_i);
    chk(chq.size(), 0);
    pulse(1'b0);
    wst(1);
    chk(chq[0], 5'h04);
    rdc(8'h0C, 32'hB0);
    $display("test triggers done");
    repeat (40) @(posedge ref_clk_i);
    wr(8'h04, 32'h04);
    // Written value lands at the completing edge; look one edge later
    @(posedge ref_clk_i);
    chk(reference_enable_o, 1'b0);
    wr(8'h0C, 32'hB2);
    wr(8'h0C, 32'hB1);
    repeat (3) @(posedge ref_clk_i);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h0C, 32'h0);
    $display("test soft reset done");
    results();
  end
endmodule : adc_mode_trigger_control_tb
